// ==== chi_pkg.sv ====
package chi_pkg;

  // ==========================================================
  // register map
  localparam int unsigned ADDR_W    = 12;
  localparam logic [11:0] OFS_RAW   = 12'h000;
  localparam logic [11:0] OFS_MASK  = 12'h004;
  localparam logic [11:0] OFS_CLEAR = 12'h008;

  // ==========================================================
  // raw status bit positions
  localparam int unsigned B_LINE3      = 19;
  localparam int unsigned B_CARD_IRQ   = 18;
  localparam int unsigned B_XFER_DONE  = 17;
  localparam int unsigned B_BLOCK_CRC  = 16;
  localparam int unsigned B_REPLY_RDY  = 15;
  localparam int unsigned B_REPLY_CRC  = 14;
  localparam int unsigned B_LINE3_LOW  = 13;
  localparam int unsigned B_LINE3_HIGH = 12;
  localparam int unsigned B_CMD_SENT   = 11;
  localparam int unsigned B_CARD_IDLE  = 10;
  localparam int unsigned B_OUT_EXT    = 9;
  localparam int unsigned B_IN_EXT     = 8;
  localparam int unsigned B_IN_BUS     = 7;
  localparam int unsigned B_OUT_BUS    = 6;
  localparam int unsigned B_IN_FULL    = 5;
  localparam int unsigned B_IN_LEVEL   = 4;
  localparam int unsigned B_IN_NONEMP  = 3;
  localparam int unsigned B_OUT_NFULL  = 2;
  localparam int unsigned B_OUT_SPACE  = 1;
  localparam int unsigned B_OUT_EMPTY  = 0;

  // ==========================================================
  // widths and reset values
  localparam int unsigned SRC_W      = 19;
  localparam int unsigned EVT_W      = 18;
  localparam logic [18:0] MASK_RESET = 19'h7_FFFF;
  localparam logic [17:0] EVT_RESET  = 18'h0_0000;
  localparam logic [1:0]  PTR_RESET  = 2'h0;
  localparam int unsigned FIFO_BYTES = 64;

  // ==========================================================
  // types
  typedef enum logic [1:0] {CHI_BYTE, CHI_HALF, CHI_WORD} chi_size_t;

  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } chi_apb_req_t;

  typedef struct packed {
    logic cmd_sent;
    logic reply_ready;
    logic reply_crc_bad;
    logic block_crc_bad;
    logic xfer_done;
    logic busy_end;
    logic out_ext_err;
    logic in_ext_err;
  } chi_card_evt_t;

  typedef struct packed {
    logic      strobe;
    chi_size_t size;
  } chi_fifo_acc_t;

endpackage

// ==== chi_irq_status.sv ====
`timescale 1ns/1ps

// Summary of operation
// RULE1: raw unmasked sources readable at offset 0x00, read only.
// RULE2: bit 19 shows the live card_line3 level, never latched.
// RULE3: bit 18 follows the card interrupt; maskable, clear register ignores it.
// RULE4: bit 17 sets when a card data transfer finishes.
// RULE5: bit 16 sets when a data block crc check fails.
// RULE6: bit 15 sets when a response sits in the response buffer.
// RULE7: bit 14 sets when a received response fails its crc.
// RULE8: bit 13 sets while data engine idle and card_line3 low.
// RULE9: bit 12 sets while data engine idle and card_line3 high.
// RULE10: bit 11 sets when the command has been fully sent.
// RULE11: bit 10 sets when the card stops signalling busy.
// RULE12: bit 9 sets on card-side transmit queue overrun or misalignment.
// RULE13: bit 8 sets on card-side receive queue underrun or misalignment.
// RULE14: bit 7 sets on bus-side receive queue underrun or misalignment.
// RULE15: bit 6 sets on bus-side transmit queue overrun or misalignment.
// RULE16: width change with byte pointer off byte 0 is a misaligned access.
// RULE17: raw status bits 18 to 0 reset to zero; bits 31 to 20 read zero.
// RULE18: bits 5 to 0 report receive and transmit queue level conditions.
// RULE19: one mask bit per source, one masks, all set at reset.
// RULE20: writing one to the clear register clears that source in bits 17 to 0; zero ignored.
// RULE21: interrupt output high when any unmasked source is set.
module chi_irq_status #(
  parameter int unsigned FIFO_DEPTH = chi_pkg::FIFO_BYTES
) (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire chi_pkg::chi_apb_req_t  apb_req,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire chi_pkg::chi_card_evt_t card_evt,
  input  wire logic                   card_irq_level,
  input  wire logic                   card_line3,
  input  wire logic                   data_idle,
  input  wire chi_pkg::chi_fifo_acc_t out_bus_wr,
  input  wire chi_pkg::chi_fifo_acc_t in_bus_rd,
  input  wire logic [7:0]             in_count,
  input  wire logic [7:0]             out_space,
  input  wire logic [7:0]             in_half_level,
  input  wire logic [7:0]             out_half_level,
  output logic                        irq
);
  import chi_pkg::*;

  // the queue counts are 8 bits wide, so deeper queues cannot be reported
  if (FIFO_DEPTH == 0 || FIFO_DEPTH > 255) begin : g_bad_depth
    $error("FIFO_DEPTH must lie in 1..255");
  end

  // ==========================================================
  // decoding helpers
  function automatic logic addr_mapped(input logic [11:0] a);
    addr_mapped = (a == OFS_RAW) || (a == OFS_MASK) || (a == OFS_CLEAR);
  endfunction

  function automatic logic [7:0] size_bytes(input chi_size_t s);
    case (s)
      CHI_BYTE: size_bytes = 8'h01;
      CHI_HALF: size_bytes = 8'h02;
      CHI_WORD: size_bytes = 8'h04;
      default:  size_bytes = 8'h04;
    endcase
  endfunction

  function automatic logic misaligned(input chi_size_t s, input chi_size_t prev,
                                      input logic [1:0] ptr);
    misaligned = (s != prev) && (ptr != PTR_RESET);
  endfunction

  // ==========================================================
  // state
  logic [EVT_W-1:0] evt_src;
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] evt_clr;
  logic [SRC_W-1:0] mask;
  logic             card_irq_q;
  logic [31:0]      status;
  logic             setup_rd;
  logic             acc_wr;
  logic [1:0]       bus_err;

  logic [7:0] depth8;
  assign depth8 = 8'(FIFO_DEPTH);

  assign setup_rd = apb_req.sel && !apb_req.enable && !apb_req.write;
  assign acc_wr   = apb_req.sel && apb_req.enable && apb_req.write;

  // ==========================================================
  // bus-side queue access trackers: 0 = transmit write, 1 = receive read
  chi_fifo_acc_t acc   [2];
  logic [7:0]    avail [2];
  assign acc[0]   = out_bus_wr;
  assign acc[1]   = in_bus_rd;
  assign avail[0] = out_space;
  assign avail[1] = in_count;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_trk
      logic [1:0] ptr;
      chi_size_t  prev;
      logic [7:0] nb;
      assign nb = size_bytes(acc[g].size);
      // RULE16: width change check
      assign bus_err[g] = acc[g].strobe &&
                          (misaligned(acc[g].size, prev, ptr) || (avail[g] < nb));
      // the byte pointer wraps modulo a word, so only its low bits matter
      always_ff @(posedge clk) begin
        if (reset) begin
          ptr  <= PTR_RESET;
          prev <= CHI_WORD;
        end else if (acc[g].strobe) begin
          ptr  <= ptr + nb[1:0];
          prev <= acc[g].size;
        end
      end
    end
  endgenerate

  // ==========================================================
  // event set terms
  always_comb begin
    evt_set = EVT_RESET;
    // RULE4: transfer done
    evt_set[B_XFER_DONE]  = card_evt.xfer_done;
    // RULE5: data crc fail
    evt_set[B_BLOCK_CRC]  = card_evt.block_crc_bad;
    // RULE6: response ready
    evt_set[B_REPLY_RDY]  = card_evt.reply_ready;
    // RULE7: response crc fail
    evt_set[B_REPLY_CRC]  = card_evt.reply_crc_bad;
    // RULE8: idle line low
    evt_set[B_LINE3_LOW]  = data_idle && !card_line3;
    // RULE9: idle line high
    evt_set[B_LINE3_HIGH] = data_idle && card_line3;
    // RULE10: command sent
    evt_set[B_CMD_SENT]   = card_evt.cmd_sent;
    // RULE11: busy ended
    evt_set[B_CARD_IDLE]  = card_evt.busy_end;
    // RULE12: card-side transmit error
    evt_set[B_OUT_EXT]    = card_evt.out_ext_err;
    // RULE13: card-side receive error
    evt_set[B_IN_EXT]     = card_evt.in_ext_err;
    // RULE14: bus-side receive error
    evt_set[B_IN_BUS]     = bus_err[1];
    // RULE15: bus-side transmit error
    evt_set[B_OUT_BUS]    = bus_err[0];
    // RULE18: queue level flags
    evt_set[B_IN_FULL]    = (in_count == depth8);
    evt_set[B_IN_LEVEL]   = (in_count > in_half_level);
    evt_set[B_IN_NONEMP]  = (in_count != 8'h00);
    evt_set[B_OUT_NFULL]  = (out_space != 8'h00);
    evt_set[B_OUT_SPACE]  = (out_space > out_half_level);
    evt_set[B_OUT_EMPTY]  = (out_space == depth8);
  end

  // RULE20: write-one clear
  assign evt_clr = (acc_wr && apb_req.addr == OFS_CLEAR) ?
                   apb_req.wdata[EVT_W-1:0] : EVT_RESET;

  // ==========================================================
  // sticky sources; a set in the clearing cycle wins
  // RULE17: zero after reset
  always_ff @(posedge clk) begin
    if (reset) begin
      evt_src <= EVT_RESET;
    end else begin
      evt_src <= (evt_src & ~evt_clr) | evt_set;
    end
  end

  // RULE3: level from card, clear register has no path here
  always_ff @(posedge clk) begin
    if (reset) begin
      card_irq_q <= 1'b0;
    end else begin
      card_irq_q <= card_irq_level;
    end
  end

  // RULE19: mask register
  always_ff @(posedge clk) begin
    if (reset) begin
      mask <= MASK_RESET;
    end else if (acc_wr && apb_req.addr == OFS_MASK) begin
      mask <= apb_req.wdata[SRC_W-1:0];
    end
  end

  // RULE21: unmasked source drives the pin
  always_ff @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |({card_irq_q, evt_src} & ~mask);
    end
  end

  // ==========================================================
  // register read path
  // RULE2: live line level
  assign status = {12'h000, card_line3, card_irq_q, evt_src};

  // read data is captured in the setup phase so it comes from flops
  // RULE1: raw status read
  always_ff @(posedge clk) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (setup_rd) begin
      case (apb_req.addr)
        OFS_RAW:  prdata <= status;
        OFS_MASK: prdata <= {13'h0000, mask};
        default:  prdata <= 32'h0000_0000;
      endcase
    end
  end

  assign pready  = 1'b1;
  assign pslverr = apb_req.sel && apb_req.enable && !addr_mapped(apb_req.addr);

  // ==========================================================
  // checks
  property p_irq_unmasked;
    @(posedge clk) disable iff (reset)
      (evt_src[B_XFER_DONE] && !mask[B_XFER_DONE]) |=> irq;
  endproperty
  a_irq_unmasked: assert property (p_irq_unmasked) else $error("irq missing"); // RULE21

  property p_line3_live;
    @(posedge clk) disable iff (reset)
      (setup_rd && apb_req.addr == OFS_RAW) |=> (prdata[B_LINE3] == $past(card_line3));
  endproperty
  a_line3_live: assert property (p_line3_live) else $error("line3 bit stale"); // RULE2

  property p_card_irq_kept;
    @(posedge clk) disable iff (reset)
      (card_irq_level && evt_clr != EVT_RESET) |=> card_irq_q;
  endproperty
  a_card_irq_kept: assert property (p_card_irq_kept) else $error("card irq cleared"); // RULE3

  property p_xfer_set;
    @(posedge clk) disable iff (reset)
      card_evt.xfer_done |=> evt_src[B_XFER_DONE] [*1] ##0 status[B_XFER_DONE];
  endproperty
  a_xfer_set: assert property (p_xfer_set) else $error("done flag not set"); // RULE4

  property p_reply_sticky;
    @(posedge clk) disable iff (reset)
      (evt_src[B_REPLY_RDY] && !evt_clr[B_REPLY_RDY]) |=> evt_src[B_REPLY_RDY];
  endproperty
  a_reply_sticky: assert property (p_reply_sticky) else $error("reply flag lost"); // RULE6

  property p_clear_one;
    @(posedge clk) disable iff (reset)
      (evt_clr[B_BLOCK_CRC] && !card_evt.block_crc_bad) |=> !evt_src[B_BLOCK_CRC];
  endproperty
  a_clear_one: assert property (p_clear_one) else $error("clear ignored"); // RULE20

  property p_line3_low;
    @(posedge clk) disable iff (reset)
      (data_idle && !card_line3) |=> evt_src[B_LINE3_LOW];
  endproperty
  a_line3_low: assert property (p_line3_low) else $error("line3 low flag missing"); // RULE8

  property p_misalign;
    @(posedge clk) disable iff (reset)
      (out_bus_wr.strobe && out_bus_wr.size != g_trk[0].prev && g_trk[0].ptr != 2'h0)
      |=> evt_src[B_OUT_BUS];
  endproperty
  a_misalign: assert property (p_misalign) else $error("misaligned write missed"); // RULE16

  property p_reserved_zero;
    @(posedge clk) disable iff (reset)
      setup_rd |=> (prdata[31:20] == 12'h000);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set"); // RULE17

  property p_block_crc_set;
    @(posedge clk) disable iff (reset)
      card_evt.block_crc_bad |=> evt_src[B_BLOCK_CRC];
  endproperty
  a_block_crc_set: assert property (p_block_crc_set) else $error("data crc flag missing"); // RULE5

  property p_reply_crc_set;
    @(posedge clk) disable iff (reset)
      card_evt.reply_crc_bad |=> evt_src[B_REPLY_CRC];
  endproperty
  a_reply_crc_set: assert property (p_reply_crc_set) else $error("reply crc flag missing"); // RULE7

  property p_line3_high;
    @(posedge clk) disable iff (reset)
      (data_idle && card_line3) |=> evt_src[B_LINE3_HIGH];
  endproperty
  a_line3_high: assert property (p_line3_high) else $error("line3 high flag missing"); // RULE9

  property p_cmd_sent;
    @(posedge clk) disable iff (reset)
      card_evt.cmd_sent |=> evt_src[B_CMD_SENT];
  endproperty
  a_cmd_sent: assert property (p_cmd_sent) else $error("command sent flag missing"); // RULE10

  property p_card_idle;
    @(posedge clk) disable iff (reset)
      card_evt.busy_end |=> evt_src[B_CARD_IDLE];
  endproperty
  a_card_idle: assert property (p_card_idle) else $error("busy end flag missing"); // RULE11

  property p_out_ext;
    @(posedge clk) disable iff (reset)
      card_evt.out_ext_err |=> evt_src[B_OUT_EXT];
  endproperty
  a_out_ext: assert property (p_out_ext) else $error("card side transmit error missing"); // RULE12

  property p_in_ext;
    @(posedge clk) disable iff (reset)
      card_evt.in_ext_err |=> evt_src[B_IN_EXT];
  endproperty
  a_in_ext: assert property (p_in_ext) else $error("card side receive error missing"); // RULE13

  property p_in_under;
    @(posedge clk) disable iff (reset)
      (in_bus_rd.strobe && in_count < size_bytes(in_bus_rd.size)) |=> evt_src[B_IN_BUS];
  endproperty
  a_in_under: assert property (p_in_under) else $error("receive underrun missed"); // RULE14

  property p_out_over;
    @(posedge clk) disable iff (reset)
      (out_bus_wr.strobe && out_space < size_bytes(out_bus_wr.size)) |=> evt_src[B_OUT_BUS];
  endproperty
  a_out_over: assert property (p_out_over) else $error("transmit overrun missed"); // RULE15

  property p_in_misalign;
    @(posedge clk) disable iff (reset)
      (in_bus_rd.strobe && in_bus_rd.size != g_trk[1].prev && g_trk[1].ptr != PTR_RESET)
      |=> evt_src[B_IN_BUS];
  endproperty
  a_in_misalign: assert property (p_in_misalign) else $error("misaligned read missed"); // RULE16

  property p_level_full;
    @(posedge clk) disable iff (reset)
      (in_count == depth8) |=> evt_src[B_IN_FULL];
  endproperty
  a_level_full: assert property (p_level_full) else $error("receive full flag missing"); // RULE18

  property p_mask_write;
    @(posedge clk) disable iff (reset)
      (acc_wr && apb_req.addr == OFS_MASK) |=> (mask == $past(apb_req.wdata[SRC_W-1:0]));
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write lost"); // RULE19

  property p_raw_read;
    @(posedge clk) disable iff (reset)
      (setup_rd && apb_req.addr == OFS_RAW) |=> (prdata == $past(status));
  endproperty
  a_raw_read: assert property (p_raw_read) else $error("raw status read wrong"); // RULE1

endmodule

// ==== chi_card_model.sv ====
`timescale 1ns/1ps

module chi_card_model (
  input  wire logic                   clk,
  input  wire chi_pkg::chi_card_evt_t evt_req,
  input  wire logic                   irq_set,
  input  wire logic                   irq_ack,
  input  wire logic                   line3_req,
  output chi_pkg::chi_card_evt_t      card_evt,
  output logic                        card_irq_level,
  output logic                        card_line3
);
  import chi_pkg::*;

  // ==========================================================
  // card side
  initial begin
    card_evt = '0;
    card_irq_level = 1'b0;
    card_line3 = 1'b0;
  end

  // each requested event reaches the host one cycle later and lasts as long as it is requested
  always @(posedge clk) card_evt <= #1 evt_req;

  // level held in card
  // only the card itself drops its interrupt, never the host clear
  always @(posedge clk) begin
    if (irq_set) card_irq_level <= #1 1'b1;
    else if (irq_ack) card_irq_level <= #1 1'b0;
  end

  always @(posedge clk) card_line3 <= #1 line3_req;
endmodule

// ==== test_chi_irq_status.sv ====
`timescale 1ns/1ps

module test_chi_irq_status;
  import chi_pkg::*;
  logic          clk;
  logic          reset;
  chi_apb_req_t  apb_req;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  chi_card_evt_t card_evt;
  chi_card_evt_t evt_req;
  logic          card_irq_level;
  logic          card_line3;
  logic          irq_set;
  logic          irq_ack;
  logic          line3_req;
  logic          data_idle;
  chi_fifo_acc_t out_bus_wr;
  chi_fifo_acc_t in_bus_rd;
  logic [7:0]    in_count;
  logic [7:0]    out_space;
  logic [7:0]    in_half_level;
  logic [7:0]    out_half_level;
  logic          irq;
  logic          err;
  logic [31:0]   rd;
  logic          rdy;
  int            miscompares = 0;
  int            total_checks = 0;
  int            cycles = 0;
  int            pos [8] = '{11, 15, 14, 16, 17, 10, 9, 8};

  chi_irq_status u_dut (.clk(clk), .reset(reset), .apb_req(apb_req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .card_evt(card_evt), .card_irq_level(card_irq_level),
    .card_line3(card_line3), .data_idle(data_idle), .out_bus_wr(out_bus_wr),
    .in_bus_rd(in_bus_rd), .in_count(in_count), .out_space(out_space),
    .in_half_level(in_half_level), .out_half_level(out_half_level), .irq(irq));

  chi_card_model u_card (.clk(clk), .evt_req(evt_req), .irq_set(irq_set), .irq_ack(irq_ack),
    .line3_req(line3_req), .card_evt(card_evt), .card_irq_level(card_irq_level),
    .card_line3(card_line3));

  // ==========================================================
  // helpers
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // the leading step keeps two transfers from touching apb_req in one time step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    step(1);
    apb_req = '{sel: 1'b1, enable: 1'b0, write: w, addr: a, wdata: d};
    step(1);
    apb_req.enable = 1'b1;
    @(posedge clk);
    rd = prdata;
    err = pslverr;
    rdy = pready;
    #1;
    apb_req = '0;
  endtask

  task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(name, rd, exp);
    chk("ready", 32'(rdy), 32'h1);
    chk("no error", 32'(err), 32'h0);
  endtask

  task automatic pulse(input chi_card_evt_t e);
    step(1);
    evt_req = e;
    step(1);
    evt_req = '0;
    step(2);
  endtask

  task automatic qacc(input logic is_rd, input chi_size_t s);
    step(1);
    if (is_rd) in_bus_rd = '{strobe: 1'b1, size: s};
    else out_bus_wr = '{strobe: 1'b1, size: s};
    step(1);
    in_bus_rd = '0;
    out_bus_wr = '0;
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================
  // clock and timeout
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      miscompares++;
      conclude();
    end
  end

  // ==========================================================
  // sequence
  initial begin
    reset = 1'b1;
    apb_req = '0;
    evt_req = '0;
    irq_set = 1'b0;
    irq_ack = 1'b0;
    line3_req = 1'b0;
    data_idle = 1'b0;
    out_bus_wr = '0;
    in_bus_rd = '0;
    in_count = 8'h00;
    out_space = 8'h00;
    in_half_level = 8'h3C;
    out_half_level = 8'h3C;
    repeat (4) @(posedge clk);
    #1;
    reset = 1'b0;
    rdchk("raw reset", OFS_RAW, 32'h0000_0000);
    rdchk("mask reset", OFS_MASK, 32'h0007_FFFF);
    apb(1'b1, OFS_RAW, 32'hFFFF_FFFF);
    rdchk("raw read only", OFS_RAW, 32'h0000_0000);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk("unmapped", 32'(err), 32'h1);
    for (int i = 0; i < 8; i++) begin
      pulse(chi_card_evt_t'(8'h80 >> i));
      rdchk("event set", OFS_RAW, 32'h1 << pos[i]);
      chk("masked irq", 32'(irq), 32'h0);
      apb(1'b1, OFS_CLEAR, 32'h1 << pos[i]);
      rdchk("event clear", OFS_RAW, 32'h0);
    end
    pulse(chi_card_evt_t'(8'h08));
    apb(1'b1, OFS_CLEAR, 32'h0000_0000);
    rdchk("clear zero", OFS_RAW, 32'h0002_0000);
    apb(1'b1, OFS_MASK, 32'h0005_FFFF);
    step(2);
    chk("irq unmasked", 32'(irq), 32'h1);
    apb(1'b1, OFS_CLEAR, 32'h0002_0000);
    step(2);
    chk("irq cleared", 32'(irq), 32'h0);
    irq_set = 1'b1;
    step(1);
    irq_set = 1'b0;
    step(3);
    rdchk("card irq", OFS_RAW, 32'h0004_0000);
    chk("card irq masked", 32'(irq), 32'h0);
    apb(1'b1, OFS_CLEAR, 32'h0007_FFFF);
    rdchk("card irq kept", OFS_RAW, 32'h0004_0000);
    apb(1'b1, OFS_MASK, 32'h0003_FFFF);
    step(2);
    chk("card irq unmasked", 32'(irq), 32'h1);
    irq_ack = 1'b1;
    step(1);
    irq_ack = 1'b0;
    step(3);
    rdchk("card irq gone", OFS_RAW, 32'h0000_0000);
    chk("card irq dropped", 32'(irq), 32'h0);
    line3_req = 1'b1;
    step(3);
    rdchk("line3 live", OFS_RAW, 32'h0008_0000);
    data_idle = 1'b1;
    step(2);
    rdchk("idle high", OFS_RAW, 32'h0008_1000);
    line3_req = 1'b0;
    step(3);
    rdchk("idle low", OFS_RAW, 32'h0000_3000);
    data_idle = 1'b0;
    apb(1'b1, OFS_CLEAR, 32'h0000_3000);
    rdchk("line3 clear", OFS_RAW, 32'h0000_0000);
    in_count = 8'h28;
    out_space = 8'h28;
    qacc(1'b0, CHI_BYTE);
    qacc(1'b1, CHI_BYTE);
    rdchk("byte access", OFS_RAW, 32'h0000_000C);
    qacc(1'b0, CHI_WORD);
    qacc(1'b1, CHI_WORD);
    rdchk("misaligned", OFS_RAW, 32'h0000_00CC);
    in_count = 8'h40;
    out_space = 8'h40;
    step(2);
    rdchk("levels", OFS_RAW, 32'h0000_00FF);
    in_count = 8'h00;
    out_space = 8'h00;
    apb(1'b1, OFS_CLEAR, 32'h0003_FFFF);
    rdchk("all clear", OFS_RAW, 32'h0000_0000);
    // same width as before, so only the empty receive queue and the full transmit queue can raise the errors
    qacc(1'b0, CHI_WORD);
    qacc(1'b1, CHI_WORD);
    rdchk("queue short", OFS_RAW, 32'h0000_00C0);
    conclude();
  end
endmodule
